/* dch_channel.sv */
// DMA channel with direct and linked-list modes behind an AXI4-Lite slave.
// Contract
// - Chain enable and flag clears are taken in the launching write.
// - Launched channel moves data until stop, bus error or count zero.
// - Direct transfer completes at count zero and sets the complete flag.
// - Current source, destination and 24-bit count stay readable during transfer.
// - Stop request ends source reads; stopped flag set after buffer drains.
// - Up to 256 bytes may still move after a stop request.
// - Linked-list mode fetches packets from the list address and runs them.
// - Packets are 32-byte aligned; little-endian on PCI, big-endian on CPU bus.
// - Packet port is chosen in attributes, independent of source and destination.
// - Address writes ignored while active; reads show current address.
// - Transfer control holds source, destination, endian mode and byte count.
// - Packet pointer holds next pointer bits 31:5 and a list-end bit.
// - Each loaded packet updates channel registers including the next pointer.
// - List walks to the end packet; complete set when it finishes.
// - Non-zero count at chained launch finishes direct first, then the list.
// - Chained stop ceases source reads; stopped set after writes complete.
// - Halt request finishes current packet, then sets halted and stops.
// - Separate write-one-to-clear error flags for each of the three buses.
// - Each flag has an enable; flag and enable together raise interrupt.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
module dch_channel
	import dch_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// AXI4-Lite write address and data.
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response.
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Bus master ports, one-hot by port.
	output logic [2:0]       port_req_o,
	output logic             port_wr_o,
	output logic [31:0]      port_addr_o,
	output logic [31:0]      port_wdata_o,
	input  wire logic [2:0]  port_done_i,
	input  wire logic [2:0]  port_err_i,
	input  wire logic [31:0] port_rdata_i,
	// Channel event outputs.
	output logic             chan_irq_o,
	output logic             chan_active_o
);

	typedef enum logic [2:0] {
		S_IDLE, S_RD, S_WR, S_PKT, S_NEXT
	} dch_state_t;

	typedef struct packed {
		dch_state_t   fsm;
		logic [31:0]  src;
		logic [31:0]  dst;
		logic [31:0]  tcr;
		logic [31:0]  cpp;
		logic [31:0]  attr;
		logic         chain;
		logic         stop_req;
		logic         halt_req;
		logic         active;
		logic [NFLAGS-1:0] flags;
		logic [NFLAGS-1:0] en;
		logic [31:0]  buf_word;
		logic [1:0]   pkt_idx;
		logic [31:0]  pkt_base;
		logic [2:0]   pkt_cpp_last;
		logic         aw_got;
		logic         w_got;
		logic [7:0]   aw_addr;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		logic         bvalid;
		logic         rvalid;
		logic [31:0]  rdata;
		logic         mreq;
		logic         irq;
	} dch_state_s_t;

	dch_state_s_t st;
	dch_state_s_t next_st;
	dch_mem_if    mem ();

	// ************************************************************
	// Port steering.
	// ************************************************************
	dch_port_mux u_mux (
		.ref_clk_i    (ref_clk_i),
		.rst_b_i      (rst_b_i),
		.ch           (mem),
		.port_req_o   (port_req_o),
		.port_wr_o    (port_wr_o),
		.port_addr_o  (port_addr_o),
		.port_wdata_o (port_wdata_o),
		.port_done_i  (port_done_i),
		.port_err_i   (port_err_i),
		.port_rdata_i (port_rdata_i)
	);

	logic [1:0]  src_port;
	logic [1:0]  dst_port;
	logic [1:0]  pkt_port;
	logic [TC_BC_W-1:0] bc;
	logic [31:0] gcsr_rd;
	logic [31:0] pkt_word;
	logic        do_write;
	logic [31:0] wmask;

	assign src_port = st.tcr[TC_SRC_LO +: 2];
	assign dst_port = st.tcr[TC_DST_LO +: 2];
	assign pkt_port = st.attr[1:0];
	assign bc       = st.tcr[TC_BC_W-1:0];

	// Packet words from processor bus memory are big-endian and swapped here.
	assign pkt_word = (pkt_port == PORT_CPU) ? {port_rdata_i[7:0], port_rdata_i[15:8],
		port_rdata_i[23:16], port_rdata_i[31:24]} : port_rdata_i;

	// Memory request follows the state; the mux holds it until answered.
	assign mem.req   = st.mreq;
	assign mem.wr    = (st.fsm == S_WR);
	assign mem.port  = (st.fsm == S_RD) ? src_port :
		(st.fsm == S_WR) ? dst_port : pkt_port;
	assign mem.addr  = (st.fsm == S_RD) ? st.src : (st.fsm == S_WR) ? st.dst :
		st.pkt_base + 32'(st.pkt_idx) * 32'(BEAT_BYTES);
	assign mem.wdata = st.buf_word;

	assign gcsr_rd = {8'h00, 2'b00, st.en, 2'b00, st.flags, 3'b000,
		st.active, st.halt_req, st.stop_req, st.chain, 1'b0};

	// Byte-lane mask for register writes.
	generate
		for (genvar i = 0; i < 4; i++) begin : g_lane
			assign wmask[i*8 +: 8] = {8{st.w_strb[i]}};
		end
	endgenerate

	assign do_write = st.aw_got && st.w_got && !st.bvalid;

	// Error flag of a bus port; the flag order differs from the port codes, so map explicitly.
	function automatic int err_flag(input logic [1:0] prt);
		return (prt == PORT_CPU) ? FL_PB : ((prt == PORT_P1) ? FL_P1 : FL_P2);
	endfunction

	// ************************************************************
	// Next-state logic.
	// ************************************************************
	always_comb begin
		logic [31:0] wv;
		logic [NFLAGS-1:0] set_f;
		logic [NFLAGS-1:0] clr_f;
		logic        err_hit;
		logic        launch;
		wv      = '0;
		set_f   = '0;
		clr_f   = '0;
		err_hit = 1'b0;
		launch  = 1'b0;
		next_st = st;
		next_st.mreq = 1'b0;

		// Bus handshakes: address and data taken in either order.
		if (s_axi_awvalid && !st.aw_got) begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_got) begin
			next_st.w_got  = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// Register writes.
		if (do_write) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			case (st.aw_addr)
				OFS_SRC: begin
					if (!st.active) begin
						next_st.src = (st.src & ~wmask) | (st.w_data & wmask);
					end
				end
				OFS_DST: begin
					if (!st.active) begin
						next_st.dst = (st.dst & ~wmask) | (st.w_data & wmask);
					end
				end
				OFS_TCR: begin
					if (!st.active) begin
						next_st.tcr = (st.tcr & ~wmask) | (st.w_data & wmask);
					end
				end
				OFS_CPP: begin
					if (!st.active) begin
						wv = (st.cpp & ~wmask) | (st.w_data & wmask);
						next_st.cpp = {wv[31:CPP_LO], 4'h0, wv[CPP_LAST]};
					end
				end
				OFS_ATTR: begin
					next_st.attr = (st.attr & ~wmask) | (st.w_data & wmask);
				end
				OFS_GCSR: begin
					wv = (gcsr_rd & ~wmask) | (st.w_data & wmask);
					clr_f = st.w_data[GC_FLAG_LO +: NFLAGS] & wmask[GC_FLAG_LO +: NFLAGS];
					next_st.en = wv[GC_EN_LO +: NFLAGS];
					if (!st.active) begin
						// Chain and flag clears act with the launch in one write.
						next_st.chain = wv[GC_CHAIN];
						launch = st.w_data[GC_GO] && wmask[GC_GO];
					end else begin
						if (st.w_data[GC_STOP_REQ] && wmask[GC_STOP_REQ]) begin
							next_st.stop_req = 1'b1;
						end
						if (st.w_data[GC_HALT_REQ] && wmask[GC_HALT_REQ]) begin
							next_st.halt_req = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads.
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			case (s_axi_araddr)
				OFS_SRC:  next_st.rdata = st.src;
				OFS_DST:  next_st.rdata = st.dst;
				OFS_TCR:  next_st.rdata = st.tcr;
				OFS_CPP:  next_st.rdata = st.cpp;
				OFS_ATTR: next_st.rdata = st.attr;
				OFS_GCSR: next_st.rdata = gcsr_rd;
				default:  next_st.rdata = RST_WORD;
			endcase
		end

		// Launch: direct remainder first when the count is not zero.
		if (launch && (st.flags & ~clr_f) == '0) begin
			next_st.active   = 1'b1;
			next_st.stop_req = 1'b0;
			next_st.halt_req = 1'b0;
			if (bc != '0) begin
				next_st.fsm  = S_RD;
				next_st.mreq = 1'b1;
			end else if (wv[GC_CHAIN]) begin
				next_st.fsm = S_NEXT;
			end else begin
				next_st.active = 1'b0;
				set_f[FL_DON]  = 1'b1;
			end
		end

		// Transfer engine.
		case (st.fsm)
			S_RD: begin
				if (mem.done) begin
					next_st.buf_word = port_rdata_i;
					next_st.src  = st.src + 32'(BEAT_BYTES);
					next_st.fsm  = S_WR;
					next_st.mreq = 1'b1;
				end else if (mem.err) begin
					set_f[err_flag(src_port)] = 1'b1;
					err_hit = 1'b1;
				end
			end
			S_WR: begin
				if (mem.done) begin
					next_st.dst = st.dst + 32'(BEAT_BYTES);
					// The count floors at zero for a short last word.
					next_st.tcr[TC_BC_W-1:0] = (bc > TC_BC_W'(BEAT_BYTES)) ?
						bc - TC_BC_W'(BEAT_BYTES) : '0;
					if (bc <= TC_BC_W'(BEAT_BYTES)) begin
						next_st.fsm = S_NEXT;
					end else if (st.stop_req) begin
						// Only one buffered word, so overrun stays far under the limit.
						next_st.fsm = S_IDLE;
						next_st.active = 1'b0;
						set_f[FL_STP]  = 1'b1;
					end else begin
						next_st.fsm  = S_RD;
						next_st.mreq = 1'b1;
					end
				end else if (mem.err) begin
					set_f[err_flag(dst_port)] = 1'b1;
					err_hit = 1'b1;
				end
			end
			S_NEXT: begin
				// Decide between done, halt, stop and the next packet.
				if (!st.chain || st.cpp[CPP_LAST]) begin
					next_st.fsm    = S_IDLE;
					next_st.active = 1'b0;
					set_f[FL_DON]  = 1'b1;
				end else if (st.halt_req) begin
					next_st.fsm    = S_IDLE;
					next_st.active = 1'b0;
					set_f[FL_HLT]  = 1'b1;
				end else if (st.stop_req) begin
					next_st.fsm    = S_IDLE;
					next_st.active = 1'b0;
					set_f[FL_STP]  = 1'b1;
				end else begin
					next_st.pkt_base = {st.cpp[31:CPP_LO], 5'h00};
					next_st.pkt_idx  = 2'h0;
					next_st.fsm      = S_PKT;
					next_st.mreq     = 1'b1;
				end
			end
			S_PKT: begin
				// Words: source, destination, control, pointer, each taken as it arrives.
				if (mem.done) begin
					if (st.pkt_idx == 2'h0) begin
						next_st.src = pkt_word;
					end else if (st.pkt_idx == 2'h1) begin
						next_st.dst = pkt_word;
					end else if (st.pkt_idx == 2'h2) begin
						next_st.tcr = pkt_word;
					end else begin
						next_st.cpp = {pkt_word[31:CPP_LO], 4'h0, pkt_word[CPP_LAST]};
					end
					if (st.pkt_idx == 2'(PKT_WORDS - 1)) begin
						next_st.fsm = (pkt_word[CPP_LAST] || bc == '0) ? S_NEXT : S_NEXT;
					end else begin
						next_st.pkt_idx = st.pkt_idx + 2'h1;
						next_st.mreq    = 1'b1;
					end
				end else if (mem.err) begin
					set_f[err_flag(pkt_port)] = 1'b1;
					err_hit = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// After a packet loads, its own count runs before the list moves on.
		if (st.fsm == S_PKT && mem.done && st.pkt_idx == 2'(PKT_WORDS - 1)) begin
			if (st.tcr[TC_BC_W-1:0] != '0) begin
				next_st.fsm  = S_RD;
				next_st.mreq = 1'b1;
			end
		end

		if (err_hit) begin
			next_st.fsm    = S_IDLE;
			next_st.active = 1'b0;
		end

		// Hardware set wins over a software clear in the same cycle.
		next_st.flags = (st.flags & ~clr_f) | set_f;
		next_st.irq   = |(next_st.flags & next_st.en);
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs, all from flip-flops except the constant response codes.
	// ************************************************************
	assign s_axi_awready = !st.aw_got;
	assign s_axi_wready  = !st.w_got;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = RESP_OK;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = RESP_OK;
	assign chan_irq_o    = st.irq;
	assign chan_active_o = st.active;

endmodule

/* dch_pkg.sv */
// Package of register offsets, field positions and constants for the DMA channel.
package dch_pkg;

	// ************************************************************
	// Register byte offsets.
	// ************************************************************
	localparam logic [7:0] OFS_SRC  = 8'h00;
	localparam logic [7:0] OFS_DST  = 8'h04;
	localparam logic [7:0] OFS_TCR  = 8'h08;
	localparam logic [7:0] OFS_CPP  = 8'h0C;
	localparam logic [7:0] OFS_ATTR = 8'h10;
	localparam logic [7:0] OFS_GCSR = 8'h14;

	// ************************************************************
	// Control and status field positions.
	// ************************************************************
	localparam int GC_GO       = 0;
	localparam int GC_CHAIN    = 1;
	localparam int GC_STOP_REQ = 2;
	localparam int GC_HALT_REQ = 3;
	localparam int GC_ACT      = 4;
	localparam int GC_FLAG_LO  = 8;
	localparam int GC_EN_LO    = 16;
	localparam int FL_P1  = 0;
	localparam int FL_P2  = 1;
	localparam int FL_PB  = 2;
	localparam int FL_STP = 3;
	localparam int FL_HLT = 4;
	localparam int FL_DON = 5;
	localparam int NFLAGS = 6;

	// Transfer control and packet pointer fields.
	localparam int TC_BC_W   = 24;
	localparam int TC_SRC_LO = 24;
	localparam int TC_DST_LO = 26;
	localparam int TC_END_LO = 28;
	localparam int CPP_LAST  = 0;
	localparam int CPP_LO    = 5;

	// Bus ports: 0 processor bus, 1 PCI one, 2 PCI two.
	localparam logic [1:0] PORT_CPU = 2'h0;
	localparam logic [1:0] PORT_P1  = 2'h1;
	localparam logic [1:0] PORT_P2  = 2'h2;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// Pipeline overrun allowed after a stop request, in bytes.
	localparam int STOP_OVERRUN_BYTES = 256;
	localparam int BEAT_BYTES         = 4;
	localparam int PKT_WORDS          = 4;

	// Response codes.
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

endpackage

/* dch_mem_if.sv */
// Interface that carries one memory word request and its answer.
interface dch_mem_if;
	logic        req;
	logic        wr;
	logic [1:0]  port;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic        done;
	logic        err;
	logic [31:0] rdata;
	modport master (output req, wr, port, addr, wdata, input done, err, rdata);
	modport port_side (input req, wr, port, addr, wdata, output done, err, rdata);
endinterface

/* dch_port_mux.sv */
// Steers a channel memory request onto one of three bus ports.
module dch_port_mux
	import dch_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Channel side.
	dch_mem_if.port_side     ch,
	// Outward request, one-hot by port.
	output logic [2:0]       port_req_o,
	output logic             port_wr_o,
	output logic [31:0]      port_addr_o,
	output logic [31:0]      port_wdata_o,
	// Outward answer.
	input  wire logic [2:0]  port_done_i,
	input  wire logic [2:0]  port_err_i,
	input  wire logic [31:0] port_rdata_i
);

	typedef struct packed {
		logic [2:0]  req;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        busy;
	} dch_mux_t;

	dch_mux_t st;
	dch_mux_t next_st;

	// A request is launched once and held until its port answers.
	always_comb begin
		next_st = st;
		if (!st.busy && ch.req) begin
			next_st.busy  = 1'b1;
			next_st.req   = 3'(3'h1 << ch.port);
			next_st.wr    = ch.wr;
			next_st.addr  = ch.addr;
			next_st.wdata = ch.wdata;
		end else if (st.busy && |(st.req & (port_done_i | port_err_i))) begin
			next_st.busy = 1'b0;
			next_st.req  = 3'h0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// The answer is only taken from the selected port.
	assign ch.done = st.busy && |(st.req & port_done_i);
	assign ch.err  = st.busy && |(st.req & port_err_i);
	assign ch.rdata = port_rdata_i;
	assign port_req_o   = st.req;
	assign port_wr_o    = st.wr;
	assign port_addr_o  = st.addr;
	assign port_wdata_o = st.wdata;

endmodule

/* dch_chk.sv */
// Concurrent checks on the ports of the DMA channel.
module dch_chk
	import dch_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Register bus.
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	// Memory ports and channel events.
	input  wire logic [2:0]  port_req_o,
	input  wire logic        port_wr_o,
	input  wire logic [31:0] port_addr_o,
	input  wire logic [2:0]  port_done_i,
	input  wire logic [2:0]  port_err_i,
	input  wire logic        chan_irq_o,
	input  wire logic        chan_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// Assertions, all in the one clock domain.
	// ************************************************************
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_req_onehot: assert property ($onehot0(port_req_o))
		else $error("more than one port requested at once");
	chk_req_holds: assert property (|port_req_o && !(|((port_done_i | port_err_i) & port_req_o))
		|=> $stable(port_req_o) && $stable(port_addr_o) && $stable(port_wr_o))
		else $error("memory request changed before its answer");
	chk_req_active: assert property (|port_req_o |-> chan_active_o)
		else $error("memory request while channel idle");
	chk_word_align: assert property (|port_req_o |-> port_addr_o[1:0] == 2'h0)
		else $error("memory request not word aligned");
	chk_err_stops: assert property (|(port_err_i & port_req_o) |-> ##[1:4] !chan_active_o)
		else $error("channel still active after a bus error");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");
	chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OK)
		else $error("write response not okay");
	chk_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("second write response without a write");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && s_axi_rresp == RESP_OK)
		else $error("read answer late or not okay");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");

	// Main scenarios reached.
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_end: cover property ($fell(chan_active_o));
	cov_err: cover property (|port_err_i);
	cov_irq: cover property (chan_irq_o);
endmodule

bind dch_channel dch_chk u_chk (.ref_clk_i, .rst_b_i, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .port_req_o, .port_wr_o, .port_addr_o, .port_done_i,
	.port_err_i, .chan_irq_o, .chan_active_o);

/* dch_mem_model.sv */
// Memory targets on the three bus ports, with slow and failing modes.
module dch_mem_model
	import dch_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Request from the channel.
	input  wire logic [2:0]  port_req_i,
	input  wire logic        port_wr_i,
	input  wire logic [31:0] port_addr_i,
	input  wire logic [31:0] port_wdata_i,
	// Bench controls.
	input  wire logic        slow_i,
	input  wire logic [2:0]  fail_i,
	// Answer.
	output logic [2:0]       port_done_o,
	output logic [2:0]       port_err_o,
	output logic [31:0]      port_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [3][256];
	logic [3:0]  wait_cnt;
	logic        gap;
	int          p;

	// Each word holds its port and index, so a misplaced copy shows.
	initial begin
		for (int q = 0; q < 3; q++) for (int i = 0; i < 256; i++) mem[q][i] = 32'h5A000000 + q * 32'h10000 + i;
	end
	assign p = port_req_i[2] ? 2 : (port_req_i[1] ? 1 : 0);

	// One answer per request; the cycle after it is skipped since the request is still the old one.
	// Read data toggles when not valid, so a late sample never looks right.
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{port_done_o, port_err_o, port_rdata_o, wait_cnt, gap} <= '0;
		end else begin
			port_done_o <= '0;
			port_err_o <= '0;
			port_rdata_o <= ~port_rdata_o;
			if (gap) begin
				gap <= 1'b0;
			end else if (|port_req_i) begin
				if (wait_cnt < (slow_i ? 4'h6 : 4'h0)) begin
					wait_cnt <= wait_cnt + 4'h1;
				end else begin
					wait_cnt <= 4'h0;
					gap <= 1'b1;
					if (fail_i[p]) port_err_o <= port_req_i;
					else port_done_o <= port_req_i;
					if (!fail_i[p] && port_wr_i) mem[p][port_addr_i[9:2]] <= port_wdata_i;
					if (!fail_i[p] && !port_wr_i) port_rdata_o <= mem[p][port_addr_i[9:2]];
				end
			end
		end
	end
endmodule

/* tb_top.sv */
// Self-checking bench for the DMA channel.
module tb_top
	import dch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk_i, rst_b_i, awv, wv, bry, arv, rry, slow, pwr;
	logic        awr, wrdy, bv, arr, rv, irq, act;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, pa, pd, prd, t, a, b;
	logic [2:0]  preq, pdone, perr, fail;
	logic [1:0]  br, rr, pp;
	int          fails = 0, samples_checked = 0, cyc = 0;

	dch_channel uut (.ref_clk_i, .rst_b_i, .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr), .port_req_o(preq),
		.port_wr_o(pwr), .port_addr_o(pa), .port_wdata_o(pd), .port_done_i(pdone),
		.port_err_i(perr), .port_rdata_i(prd), .chan_irq_o(irq), .chan_active_o(act));
	dch_mem_model u_mem (.ref_clk_i, .rst_b_i, .port_req_i(preq), .port_wr_i(pwr),
		.port_addr_i(pa), .port_wdata_i(pd), .slow_i(slow), .fail_i(fail),
		.port_done_o(pdone), .port_err_o(perr), .port_rdata_o(prd));

	// ************************************************************
	// Clock, timeout and shared tasks.
	// ************************************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] pat(input int q, i);
		return 32'h5A000000 + q * 32'h10000 + i;
	endfunction
	task automatic chk(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Each bus task starts one edge on, so a ready dropped by the last one is never raised in the same step.
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge ref_clk_i);
		awv <= 1'b1; awa <= ad; wv <= 1'b1; wd <= d;
		do begin
			@(posedge ref_clk_i);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (bv !== 1'b1);
		// Ready comes late on purpose, so the response must stand while it waits.
		bry <= 1'b1;
		@(posedge ref_clk_i);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge ref_clk_i);
		arv <= 1'b1; ara <= ad;
		do begin
			@(posedge ref_clk_i);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b1;
		@(posedge ref_clk_i);
		d = rdat;
		rry <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		rd(ad, t);
		chk(t, e);
	endtask
	task automatic idle;
		do @(posedge ref_clk_i); while (act !== 1'b0);
		repeat (2) @(posedge ref_clk_i);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ************************************************************
	// Test sequence.
	// ************************************************************
	initial begin
		{rst_b_i, awv, wv, bry, arv, rry, slow, awa, ara, wd, fail} = '0;
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		// Reset values, then an unmapped place that must stay zero.
		for (int i = 0; i <= 'h18; i += 4) rc(8'(i), RST_WORD);
		wr(8'h18, 32'hFFFFFFFF);
		rc(8'h18, RST_WORD);
		$display("test reset values done");
		// Direct transfer with slow targets and the complete interrupt enabled.
		slow <= 1'b1;
		wr(OFS_SRC, 32'h100);
		wr(OFS_DST, 32'h200);
		wr(OFS_TCR, {4'h0, PORT_P1, PORT_CPU, 24'd16});
		wr(OFS_GCSR, 32'h0020_0001);
		wr(OFS_SRC, 32'h3FC);
		rd(OFS_GCSR, t);
		chk(32'(t[GC_ACT]), 32'h1);
		idle;
		rc(OFS_SRC, 32'h110);
		rc(OFS_DST, 32'h210);
		rc(OFS_TCR, {4'h0, PORT_P1, PORT_CPU, 24'd0});
		for (int i = 0; i < 4; i++) chk(u_mem.mem[1][128 + i], pat(0, 64 + i));
		rd(OFS_GCSR, t);
		chk(32'(t[13:8]), 32'h20);
		chk(32'(irq), 32'h1);
		wr(OFS_GCSR, 32'h0020_2000);
		idle;
		chk(32'(irq), 32'h0);
		$display("test direct done");
		// Stop in mid-transfer, then restart with the flag cleared in the launching write.
		wr(OFS_SRC, 32'h100);
		wr(OFS_DST, 32'h300);
		wr(OFS_TCR, {4'h0, PORT_P2, PORT_CPU, 24'd64});
		wr(OFS_GCSR, 32'h1);
		wr(OFS_GCSR, 32'h4);
		idle;
		rd(OFS_GCSR, t);
		chk(32'(t[13:8]), 32'h08);
		rd(OFS_SRC, a);
		rd(OFS_DST, b);
		rd(OFS_TCR, t);
		chk(32'(t[23:0] != 0), 32'h1);
		chk(a - 32'h100, 32'd64 - t[23:0]);
		chk(b - 32'h300, a - 32'h100);
		wr(OFS_GCSR, 32'h0000_0801);
		idle;
		rd(OFS_GCSR, t);
		chk(32'(t[13:8]), 32'h20);
		for (int i = 0; i < 16; i++) chk(u_mem.mem[2][192 + i], pat(0, 64 + i));
		$display("test stop and restart done");
		// Destination error on the first PCI port.
		fail <= 3'b010;
		wr(OFS_SRC, 32'h100);
		wr(OFS_DST, 32'h200);
		wr(OFS_TCR, {4'h0, PORT_P1, PORT_CPU, 24'd8});
		wr(OFS_GCSR, 32'h0000_2001);
		idle;
		rd(OFS_GCSR, t);
		chk(32'(t[13:8]), 32'h01);
		wr(OFS_GCSR, 32'h0000_0100);
		rd(OFS_GCSR, t);
		chk(32'(t[13:8]), 32'h00);
		fail <= 3'b000;
		slow <= 1'b0;
		$display("test bus error done");
		// Two-packet list, once from the first PCI port and once from the processor bus.
		for (int k = 0; k < 2; k++) begin
			pp = k ? PORT_CPU : PORT_P1;
			for (int j = 0; j < 8; j++) begin
				case (j)
					0: a = 32'h180; 1: a = 32'h080 + k * 32'h40;
					2, 6: a = {4'h0, PORT_P2, PORT_CPU, 24'd8}; 3: a = 32'h3A0;
					4: a = 32'h188; 5: a = 32'h088 + k * 32'h40; default: a = 32'h1;
				endcase
				u_mem.mem[pp][224 + j + (j / 4) * 4] = k ? {<<8{a}} : a;
			end
			wr(OFS_ATTR, {30'h0, pp});
			wr(OFS_TCR, 32'h0);
			wr(OFS_CPP, 32'h380);
			wr(OFS_GCSR, 32'h0000_2003);
			wr(OFS_GCSR, 32'h0000_000A);
			idle;
			rd(OFS_GCSR, t);
			chk(32'(t[13:8]), 32'h10);
			rc(OFS_CPP, 32'h3A0);
			wr(OFS_GCSR, 32'h0000_1003);
			idle;
			rd(OFS_GCSR, t);
			chk(32'(t[13:8]), 32'h20);
			rc(OFS_CPP, 32'h1);
			for (int i = 0; i < 4; i++) chk(u_mem.mem[2][32 + 16 * k + i], pat(0, 96 + i));
		end
		$display("test linked list done");
		report_and_stop();
	end
endmodule
